//--- uaaf_pkg.sv
// Constants, types and state layout of the auto-baud asynchronous port
// ----------------------------------------------------------------------
// How it works
// - Auto-baud runs only in asynchronous mode, with wake-on-break set or clear.
// - A start bit while auto-baud is enabled begins a measurement.
// - Enabling auto-baud clears the divisor, then waits for a start.
// - Count from first rising edge; result stays in divisor at fifth.
// - Hardware clears auto-baud enable at the fifth rising edge.
// - Counter rollover sets overflow; software may set or clear it.
// - Rollover leaves measurement running and enable set.
// - Counter ticks at oscillator /512, /128, /128 or /32 by mode.
// - Both divisor bytes count as one 16-bit counter in measurement.
// - Receiver is held idle while measurement runs.
// - Receive-done rises at fifth edge; reading receive data clears it.
// - With wake-on-break set, measure the byte after the break.
// - Clearing the synchronous select bit gives asynchronous mode.
// - Frame is NRZ: one start, eight or nine data, one stop.
// - Data shifts least significant bit first both ways.
// - Transmitter and receiver run independently, same format and rate.
// - Baud clock is 4, 16 or 64 times the bit rate by mode.
// - No hardware parity; ninth bit is carried as plain data.
// - Polarity bits invert transmit line and sampled receive line.
// ----------------------------------------------------------------------
package uaaf_pkg;
  // Register indices
  localparam logic [2:0] ADDR_TX_CTRL   = 3'h0;
  localparam logic [2:0] ADDR_RX_CTRL   = 3'h1;
  localparam logic [2:0] ADDR_BAUD_CTRL = 3'h2;
  localparam logic [2:0] ADDR_DIV_LOW   = 3'h3;
  localparam logic [2:0] ADDR_DIV_HIGH  = 3'h4;
  localparam logic [2:0] ADDR_RX_DATA   = 3'h5;
  localparam logic [2:0] ADDR_TX_DATA   = 3'h6;
  localparam logic [2:0] ADDR_STATUS    = 3'h7;
  // Transmit control fields
  localparam int TXC_NINE  = 6;
  localparam int TXC_EN    = 5;
  localparam int TXC_SYNC  = 4;
  localparam int TXC_HS    = 2;
  localparam int TXC_EMPTY = 1;
  localparam int TXC_NINTH = 0;
  // Receive control fields
  localparam int RXC_NINE  = 6;
  localparam int RXC_EN    = 4;
  localparam int RXC_FERR  = 2;
  localparam int RXC_OERR  = 1;
  localparam int RXC_NINTH = 0;
  // Baud control fields
  localparam int BC_OVF  = 7;
  localparam int BC_IDLE = 6;
  localparam int BC_RXP  = 5;
  localparam int BC_TXP  = 4;
  localparam int BC_WIDE = 3;
  localparam int BC_WAKE = 1;
  localparam int BC_ABEN = 0;
  // Status fields
  localparam int ST_TXBE = 1;
  localparam int ST_DONE = 0;
  // Measurement prescaler terminal counts
  localparam logic [8:0] PRE_DIV512 = 9'h1ff;
  localparam logic [8:0] PRE_DIV128 = 9'h07f;
  localparam logic [8:0] PRE_DIV32  = 9'h01f;
  // Oversampling terminal counts
  localparam logic [5:0] OSR_X64 = 6'h3f;
  localparam logic [5:0] OSR_X16 = 6'h0f;
  localparam logic [5:0] OSR_X4  = 6'h03;
  // Rising edges in one calibration byte
  localparam logic [2:0] AB_EDGE_COUNT = 3'h5;

  typedef enum logic [2:0] {
    AB_IDLE  = 3'b000,
    AB_BREAK = 3'b001,
    AB_START = 3'b011,
    AB_FIRST = 3'b010,
    AB_COUNT = 3'b110
  } uaaf_ab_state_type;

  typedef enum logic [1:0] {
    SH_IDLE  = 2'b00,
    SH_START = 2'b01,
    SH_DATA  = 2'b11,
    SH_STOP  = 2'b10
  } uaaf_shift_state_type;

  typedef struct packed {
    logic                 nine_tx;
    logic                 tx_en;
    logic                 sync_mode;
    logic                 high_speed_sel;
    logic                 tx_ninth;
    logic                 nine_rx;
    logic                 rx_en;
    logic                 rx_ferr;
    logic                 rx_oerr;
    logic                 rx_ninth;
    logic                 autobaud_overflow;
    logic                 rx_polarity;
    logic                 tx_polarity;
    logic                 wide_divisor_sel;
    logic                 wake_on_break_en;
    logic                 autobaud_en;
    logic [15:0]          divisor;
    logic [7:0]           rx_data;
    logic                 rx_done_flag;
    logic [8:0]           tx_buf;
    logic                 tx_full;
    uaaf_ab_state_type    ab_state;
    logic [2:0]           ab_edges;
    logic [8:0]           ab_pre;
    logic                 break_low;
    logic [15:0]          brg_cnt;
    uaaf_shift_state_type rx_state;
    logic [5:0]           rx_os;
    logic [3:0]           rx_bits;
    logic [8:0]           rx_shift;
    uaaf_shift_state_type tx_state;
    logic [5:0]           tx_os;
    logic [3:0]           tx_bits;
    logic [8:0]           tx_shift;
    logic                 tx_line;
    logic                 rx_prev;
    logic                 tx_pin;
    logic [7:0]           rdata;
  } uaaf_state_type;

  localparam uaaf_state_type STATE_RESET = '{
    ab_state: AB_IDLE,
    rx_state: SH_IDLE,
    tx_state: SH_IDLE,
    tx_line:  1'b1,
    rx_prev:  1'b1,
    tx_pin:   1'b1,
    default:  '0
  };
endpackage

//--- uaaf_top.sv
// Auto-baud asynchronous serial port core with its register port
`timescale 1ns/1ps
`default_nettype none
module uaaf_top #(
  parameter int DIV_WIDTH = 16            // Divisor counter width
) (
  input  wire logic       CLK,            // System clock, 20 MHz
  input  wire logic       NRST,           // Async reset, active low
  input  wire logic [2:0] ADDR,           // Register index
  input  wire logic [7:0] WDATA,          // Write data
  input  wire logic       WR,             // Write strobe
  input  wire logic       RD,             // Read strobe
  output logic      [7:0] RDATA,          // Read data, cycle after RD
  input  wire logic       RX,             // Receive line
  output logic            TX,             // Transmit line
  output logic            RX_DONE         // Receive-done flag level
);

  // --------------------------------------------------------------------
  // Elaboration check
  // --------------------------------------------------------------------
  if (DIV_WIDTH != 16) begin : g_chk
    $error("uaaf_top serves a 16-bit divisor only");
  end

  uaaf_pkg::uaaf_state_type s_reg;
  uaaf_pkg::uaaf_state_type s_next;

  logic       rx_now;
  logic       rise;
  logic       fall;
  logic [1:0] mode;
  logic [5:0] osr_m1;
  logic [5:0] osr_half;
  logic [8:0] ab_mask;
  logic [15:0] div_eff;
  logic       ab_busy;
  logic [3:0] rx_last;
  logic [3:0] tx_last;

  // --------------------------------------------------------------------
  // Line conditioning and mode decode
  // --------------------------------------------------------------------
  // Sampled receive line with polarity applied
  assign rx_now = RX ^ s_reg.rx_polarity;
  assign rise   = rx_now & ~s_reg.rx_prev;
  assign fall   = ~rx_now & s_reg.rx_prev;
  assign mode   = {s_reg.wide_divisor_sel, s_reg.high_speed_sel};
  assign ab_busy = s_reg.ab_state != uaaf_pkg::AB_IDLE;

  // Baud ticks per bit: x64, x16, or x4 with both selects set
  assign osr_m1 = (mode == 2'b00) ? uaaf_pkg::OSR_X64 :
                  (mode == 2'b11) ? uaaf_pkg::OSR_X4 :
                  uaaf_pkg::OSR_X16;
  assign osr_half = {1'b0, osr_m1[5:1]};

  // Measurement counter clock divider
  assign ab_mask = (mode == 2'b00) ? uaaf_pkg::PRE_DIV512 :
                   (mode == 2'b11) ? uaaf_pkg::PRE_DIV32 :
                   uaaf_pkg::PRE_DIV128;

  // Only the low byte divides in 8-bit mode
  assign div_eff = s_reg.wide_divisor_sel ? s_reg.divisor :
                   {8'h00, s_reg.divisor[7:0]};

  // Last data bit index, eight or nine bits
  assign rx_last = s_reg.nine_rx ? 4'h8 : 4'h7;
  assign tx_last = s_reg.nine_tx ? 4'h8 : 4'h7;

  // --------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------
  always_comb begin
    logic baud_tick;
    logic ovf_set;
    logic done_set;
    logic done_clr;
    logic rx_store;
    baud_tick = 1'b0;
    ovf_set   = 1'b0;
    done_set  = 1'b0;
    done_clr  = 1'b0;
    rx_store  = 1'b0;
    s_next    = s_reg;
    s_next.rx_prev = rx_now;

    // Register writes
    if (WR) begin
      case (ADDR)
        uaaf_pkg::ADDR_TX_CTRL: begin
          s_next.nine_tx        = WDATA[uaaf_pkg::TXC_NINE];
          s_next.tx_en          = WDATA[uaaf_pkg::TXC_EN];
          s_next.sync_mode      = WDATA[uaaf_pkg::TXC_SYNC];
          s_next.high_speed_sel = WDATA[uaaf_pkg::TXC_HS];
          s_next.tx_ninth       = WDATA[uaaf_pkg::TXC_NINTH];
        end
        uaaf_pkg::ADDR_RX_CTRL: begin
          s_next.nine_rx = WDATA[uaaf_pkg::RXC_NINE];
          s_next.rx_en   = WDATA[uaaf_pkg::RXC_EN];
          s_next.rx_ferr = s_reg.rx_ferr & WDATA[uaaf_pkg::RXC_FERR];
          s_next.rx_oerr = s_reg.rx_oerr & WDATA[uaaf_pkg::RXC_OERR];
        end
        uaaf_pkg::ADDR_BAUD_CTRL: begin
          s_next.autobaud_overflow = WDATA[uaaf_pkg::BC_OVF];
          s_next.rx_polarity      = WDATA[uaaf_pkg::BC_RXP];
          s_next.tx_polarity      = WDATA[uaaf_pkg::BC_TXP];
          s_next.wide_divisor_sel = WDATA[uaaf_pkg::BC_WIDE];
          s_next.wake_on_break_en = WDATA[uaaf_pkg::BC_WAKE];
          s_next.autobaud_en      = WDATA[uaaf_pkg::BC_ABEN];
        end
        uaaf_pkg::ADDR_DIV_LOW: begin
          if (!ab_busy) begin
            s_next.divisor[7:0] = WDATA;
          end
        end
        uaaf_pkg::ADDR_DIV_HIGH: begin
          if (!ab_busy) begin
            s_next.divisor[15:8] = WDATA;
          end
        end
        uaaf_pkg::ADDR_TX_DATA: begin
          // Transmit buffer is locked out during measurement
          if (!s_reg.autobaud_en && !s_reg.tx_full) begin
            s_next.tx_buf  = {s_reg.tx_ninth, WDATA};
            s_next.tx_full = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end

    // Register reads, data stand for one cycle only
    s_next.rdata = 8'h00;
    if (RD) begin
      case (ADDR)
        uaaf_pkg::ADDR_TX_CTRL: begin
          s_next.rdata[uaaf_pkg::TXC_NINE]  = s_reg.nine_tx;
          s_next.rdata[uaaf_pkg::TXC_EN]    = s_reg.tx_en;
          s_next.rdata[uaaf_pkg::TXC_SYNC]  = s_reg.sync_mode;
          s_next.rdata[uaaf_pkg::TXC_HS]    = s_reg.high_speed_sel;
          s_next.rdata[uaaf_pkg::TXC_EMPTY] =
            s_reg.tx_state == uaaf_pkg::SH_IDLE;
          s_next.rdata[uaaf_pkg::TXC_NINTH] = s_reg.tx_ninth;
        end
        uaaf_pkg::ADDR_RX_CTRL: begin
          s_next.rdata[uaaf_pkg::RXC_NINE]  = s_reg.nine_rx;
          s_next.rdata[uaaf_pkg::RXC_EN]    = s_reg.rx_en;
          s_next.rdata[uaaf_pkg::RXC_FERR]  = s_reg.rx_ferr;
          s_next.rdata[uaaf_pkg::RXC_OERR]  = s_reg.rx_oerr;
          s_next.rdata[uaaf_pkg::RXC_NINTH] = s_reg.rx_ninth;
        end
        uaaf_pkg::ADDR_BAUD_CTRL: begin
          s_next.rdata[uaaf_pkg::BC_OVF]  = s_reg.autobaud_overflow;
          s_next.rdata[uaaf_pkg::BC_IDLE] =
            s_reg.rx_state == uaaf_pkg::SH_IDLE;
          s_next.rdata[uaaf_pkg::BC_RXP]  = s_reg.rx_polarity;
          s_next.rdata[uaaf_pkg::BC_TXP]  = s_reg.tx_polarity;
          s_next.rdata[uaaf_pkg::BC_WIDE] = s_reg.wide_divisor_sel;
          s_next.rdata[uaaf_pkg::BC_WAKE] = s_reg.wake_on_break_en;
          s_next.rdata[uaaf_pkg::BC_ABEN] = s_reg.autobaud_en;
        end
        uaaf_pkg::ADDR_DIV_LOW: begin
          s_next.rdata = s_reg.divisor[7:0];
        end
        uaaf_pkg::ADDR_DIV_HIGH: begin
          s_next.rdata = s_reg.divisor[15:8];
        end
        uaaf_pkg::ADDR_RX_DATA: begin
          s_next.rdata = s_reg.rx_data;
          done_clr     = 1'b1;
        end
        uaaf_pkg::ADDR_STATUS: begin
          s_next.rdata[uaaf_pkg::ST_TXBE] = ~s_reg.tx_full;
          s_next.rdata[uaaf_pkg::ST_DONE] = s_reg.rx_done_flag;
        end
        default: begin
        end
      endcase
    end

    // Baud generator, stopped while it serves as measurement counter
    if (!ab_busy) begin
      if (s_reg.brg_cnt == 16'h0000) begin
        s_next.brg_cnt = div_eff;
        baud_tick      = 1'b1;
      end else begin
        s_next.brg_cnt = s_reg.brg_cnt - 16'h0001;
      end
    end else begin
      s_next.brg_cnt = 16'h0000;
    end

    // Auto-baud measurement sequencer
    if (ab_busy && !s_reg.autobaud_en) begin
      s_next.ab_state = uaaf_pkg::AB_IDLE;
    end else begin
      case (s_reg.ab_state)
        uaaf_pkg::AB_IDLE: begin
          // Only asynchronous mode may calibrate
          if (s_reg.autobaud_en && !s_reg.sync_mode) begin
            s_next.divisor   = 16'h0000;
            s_next.break_low = 1'b0;
            s_next.ab_state  = s_reg.wake_on_break_en ?
                               uaaf_pkg::AB_BREAK : uaaf_pkg::AB_START;
          end
        end
        uaaf_pkg::AB_BREAK: begin
          // Let the break pass, then measure the next byte
          if (!rx_now) begin
            s_next.break_low = 1'b1;
          end else if (s_reg.break_low) begin
            s_next.wake_on_break_en = 1'b0;
            s_next.ab_state         = uaaf_pkg::AB_START;
          end
        end
        uaaf_pkg::AB_START: begin
          if (!rx_now) begin
            s_next.ab_state = uaaf_pkg::AB_FIRST;
          end
        end
        uaaf_pkg::AB_FIRST: begin
          if (rise) begin
            s_next.ab_state = uaaf_pkg::AB_COUNT;
            s_next.ab_edges = 3'h1;
            s_next.ab_pre   = 9'h000;
          end
        end
        uaaf_pkg::AB_COUNT: begin
          s_next.ab_pre = s_reg.ab_pre + 9'h001;
          if (s_reg.ab_pre == ab_mask) begin
            s_next.ab_pre  = 9'h000;
            s_next.divisor = s_reg.divisor + 16'h0001;
            // Wrap keeps counting; enable is left alone
            if (s_reg.divisor == 16'hffff) begin
              ovf_set = 1'b1;
            end
          end
          if (rise) begin
            s_next.ab_edges = s_reg.ab_edges + 3'h1;
            if (s_reg.ab_edges == uaaf_pkg::AB_EDGE_COUNT - 3'h1) begin
              s_next.autobaud_en = 1'b0;
              s_next.ab_state    = uaaf_pkg::AB_IDLE;
              done_set           = 1'b1;
            end
          end
        end
        default: begin
          s_next.ab_state = uaaf_pkg::AB_IDLE;
        end
      endcase
    end

    // Receiver, own bit timer; held idle during measurement
    if (ab_busy || s_reg.autobaud_en || !s_reg.rx_en) begin
      s_next.rx_state = uaaf_pkg::SH_IDLE;
    end else begin
      case (s_reg.rx_state)
        uaaf_pkg::SH_IDLE: begin
          if (fall) begin
            s_next.rx_state = uaaf_pkg::SH_START;
            s_next.rx_os    = 6'h00;
          end
        end
        uaaf_pkg::SH_START: begin
          if (baud_tick) begin
            s_next.rx_os = s_reg.rx_os + 6'h01;
            // Mid start bit: false start returns to idle
            if (s_reg.rx_os == osr_half) begin
              s_next.rx_os    = 6'h00;
              s_next.rx_bits  = 4'h0;
              s_next.rx_state = rx_now ? uaaf_pkg::SH_IDLE :
                                uaaf_pkg::SH_DATA;
            end
          end
        end
        uaaf_pkg::SH_DATA: begin
          if (baud_tick) begin
            s_next.rx_os = s_reg.rx_os + 6'h01;
            if (s_reg.rx_os == osr_m1) begin
              s_next.rx_os    = 6'h00;
              s_next.rx_shift = {rx_now, s_reg.rx_shift[8:1]};
              s_next.rx_bits  = s_reg.rx_bits + 4'h1;
              if (s_reg.rx_bits == rx_last) begin
                s_next.rx_state = uaaf_pkg::SH_STOP;
              end
            end
          end
        end
        uaaf_pkg::SH_STOP: begin
          if (baud_tick) begin
            s_next.rx_os = s_reg.rx_os + 6'h01;
            if (s_reg.rx_os == osr_m1) begin
              rx_store        = 1'b1;
              s_next.rx_state = uaaf_pkg::SH_IDLE;
            end
          end
        end
        default: begin
          s_next.rx_state = uaaf_pkg::SH_IDLE;
        end
      endcase
    end

    // Received byte; ninth bit kept raw, no parity check
    if (rx_store) begin
      if (s_reg.rx_done_flag && !done_clr) begin
        s_next.rx_oerr = 1'b1;
      end else begin
        // Nine bits fill the whole shifter, eight leave bit 0 stale
        s_next.rx_data  = s_reg.nine_rx ? s_reg.rx_shift[7:0] :
                          s_reg.rx_shift[8:1];
        s_next.rx_ninth = s_reg.nine_rx & s_reg.rx_shift[8];
        s_next.rx_ferr  = ~rx_now;
        done_set        = 1'b1;
      end
    end

    // Transmitter, own bit timer, shares rate and format
    case (s_reg.tx_state)
      uaaf_pkg::SH_IDLE: begin
        if (s_reg.tx_full && s_reg.tx_en && !ab_busy) begin
          s_next.tx_shift = s_reg.tx_buf;
          s_next.tx_full  = 1'b0;
          s_next.tx_os    = 6'h00;
          s_next.tx_bits  = 4'h0;
          s_next.tx_line  = 1'b0;
          s_next.tx_state = uaaf_pkg::SH_START;
        end
      end
      uaaf_pkg::SH_START: begin
        if (baud_tick) begin
          s_next.tx_os = s_reg.tx_os + 6'h01;
          if (s_reg.tx_os == osr_m1) begin
            s_next.tx_os    = 6'h00;
            s_next.tx_line  = s_reg.tx_shift[0];
            s_next.tx_shift = {1'b0, s_reg.tx_shift[8:1]};
            s_next.tx_state = uaaf_pkg::SH_DATA;
          end
        end
      end
      uaaf_pkg::SH_DATA: begin
        if (baud_tick) begin
          s_next.tx_os = s_reg.tx_os + 6'h01;
          if (s_reg.tx_os == osr_m1) begin
            s_next.tx_os   = 6'h00;
            s_next.tx_bits = s_reg.tx_bits + 4'h1;
            if (s_reg.tx_bits == tx_last) begin
              s_next.tx_line  = 1'b1;
              s_next.tx_state = uaaf_pkg::SH_STOP;
            end else begin
              s_next.tx_line  = s_reg.tx_shift[0];
              s_next.tx_shift = {1'b0, s_reg.tx_shift[8:1]};
            end
          end
        end
      end
      uaaf_pkg::SH_STOP: begin
        if (baud_tick) begin
          s_next.tx_os = s_reg.tx_os + 6'h01;
          if (s_reg.tx_os == osr_m1) begin
            s_next.tx_state = uaaf_pkg::SH_IDLE;
          end
        end
      end
      default: begin
        s_next.tx_state = uaaf_pkg::SH_IDLE;
        s_next.tx_line  = 1'b1;
      end
    endcase

    // Hardware events win over software clears
    if (done_clr) begin
      s_next.rx_done_flag = 1'b0;
    end
    if (done_set) begin
      s_next.rx_done_flag = 1'b1;
    end
    if (ovf_set) begin
      s_next.autobaud_overflow = 1'b1;
    end

    // Pin driven from a flop, polarity applied
    s_next.tx_pin = s_next.tx_line ^ s_next.tx_polarity;
  end

  // --------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      s_reg <= uaaf_pkg::STATE_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs
  assign RDATA   = s_reg.rdata;
  assign TX      = s_reg.tx_pin;
  assign RX_DONE = s_reg.rx_done_flag;

endmodule
`default_nettype wire

//--- uaaf_sva.sv
// Port checker for the auto-baud serial port
`timescale 1ns/1ps
`default_nettype none
module uaaf_sva (
  input wire logic       CLK,     // System clock
  input wire logic       NRST,    // Reset, active low
  input wire logic [2:0] ADDR,    // Register index
  input wire logic [7:0] WDATA,   // Write data
  input wire logic       WR,      // Write strobe
  input wire logic       RD,      // Read strobe
  input wire logic [7:0] RDATA,   // Read data
  input wire logic       RX,      // Receive line
  input wire logic       TX,      // Transmit line
  input wire logic       RX_DONE  // Receive-done flag
);
  logic       sync_reg;
  logic       rd_q;
  logic [2:0] addr_q;
  logic       done_q;
  // --------
  // Shadows
  // --------
  // Sync select copy and last-cycle bus view
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      sync_reg <= 1'b0;
      rd_q     <= 1'b0;
      addr_q   <= 3'h0;
      done_q   <= 1'b0;
    end else begin
      if (WR && ADDR == uaaf_pkg::ADDR_TX_CTRL)
        sync_reg <= WDATA[uaaf_pkg::TXC_SYNC];
      rd_q   <= RD;
      addr_q <= ADDR;
      done_q <= RX_DONE;
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);
  sequence ab_arm;
    WR && ADDR == uaaf_pkg::ADDR_BAUD_CTRL && WDATA[0] && !sync_reg;
  endsequence
  sequence div_peek;
    RD && ADDR == uaaf_pkg::ADDR_DIV_LOW;
  endsequence
  // --------
  // Properties
  // --------
  a_reset_idle: assert property ($rose(NRST) |-> TX && !RX_DONE)
    else $error("port not idle after reset");
  a_rdata_quiet: assert property (!rd_q |-> RDATA == 8'h00)
    else $error("read data without a read");
  a_txdata_wo: assert property (
    rd_q && addr_q == uaaf_pkg::ADDR_TX_DATA |-> RDATA == 8'h00)
    else $error("transmit data readable");
  a_abd_clear: assert property (ab_arm ##2 div_peek |=> RDATA == 8'h00)
    else $error("divisor not cleared on enable");
  a_done_rise: assert property ($rose(RX_DONE) |-> RX)
    else $error("done raised with line low");
  a_done_clear: assert property (
    RD && ADDR == uaaf_pkg::ADDR_RX_DATA && RX_DONE |=> !RX_DONE)
    else $error("done not cleared by read");
  a_done_hold: assert property (
    RX_DONE && !(RD && ADDR == uaaf_pkg::ADDR_RX_DATA) |=> RX_DONE)
    else $error("done dropped without read");
  a_status_done: assert property (rd_q && addr_q == uaaf_pkg::ADDR_STATUS
    |-> RDATA[0] == done_q && RDATA[7:2] == 6'h00)
    else $error("status flag mismatch");
endmodule
bind uaaf_top uaaf_sva chk_u (.CLK, .NRST, .ADDR, .WDATA, .WR, .RD,
  .RDATA, .RX, .TX, .RX_DONE);
`default_nettype wire

//--- uaaf_remote.sv
// Remote asynchronous node driving the receive line
`timescale 1ns/1ps
`default_nettype none
module uaaf_remote (
  input  wire logic clk,      // Bench clock
  output var logic  rx_line   // Line into the port, idle high
);
  // Line idles high between frames
  initial rx_line = 1'b1;
  // Send one frame, bt clocks per bit
  task automatic send(input logic [7:0] b, input int bt);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rx_line <= f[i];
      repeat (bt) @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

//--- uaaf_tb_top.sv
// Self-checking bench for the auto-baud serial port
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin \
  bad_count++; $display("[FAIL] %0t got %h exp %h", $time, got, exp); end end
module uaaf_tb_top;
  logic       clk;      // Bench clock
  logic       nrst;     // Reset, active low
  logic [2:0] addr;     // Register index
  logic [7:0] wdata;    // Write data
  logic       wr;       // Write strobe
  logic       rd;       // Read strobe
  logic [7:0] rdata;    // Read data
  logic       rx;       // Receive line
  logic       tx;       // Transmit line
  logic       rx_done;  // Receive-done flag
  logic [7:0] q;        // Last read value
  logic [9:0] fr;       // Expected transmit frame
  int         bad_count;
  int         n_checks;

  uaaf_top dut_u (.CLK(clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .RX(rx), .TX(tx), .RX_DONE(rx_done));
  uaaf_remote rem_u (.clk(clk), .rx_line(rx));

  // 50 ns clock
  initial clk = 1'b0;
  always #25 clk = ~clk;

  // --------
  // Bus tasks
  // --------
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_reg(input logic [2:0] a, output logic [7:0] v);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
    @(posedge clk);
  endtask
  task automatic conclude;
    if (bad_count == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (8000) @(posedge clk);
    bad_count++;
    conclude();
  end

  // --------
  // Tests
  // --------
  initial begin
    {nrst, addr, wdata, wr, rd, bad_count, n_checks} = '0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    #1 `CHK(tx, 1'b1)
    rd_reg(uaaf_pkg::ADDR_BAUD_CTRL, q);
    `CHK(q & 8'hbf, 8'h00)
    wr_reg(uaaf_pkg::ADDR_TX_CTRL, 8'h24);
    wr_reg(uaaf_pkg::ADDR_BAUD_CTRL, 8'h08);
    wr_reg(uaaf_pkg::ADDR_DIV_LOW, 8'h03);
    wr_reg(uaaf_pkg::ADDR_DIV_HIGH, 8'h00);
    wr_reg(uaaf_pkg::ADDR_RX_CTRL, 8'h10);
    rem_u.send(8'h3c, 16);
    #1 `CHK(rx_done, 1'b1)
    rd_reg(uaaf_pkg::ADDR_RX_DATA, q);
    `CHK(q, 8'h3c)
    #1 `CHK(rx_done, 1'b0)
    rd_reg(uaaf_pkg::ADDR_TX_DATA, q);
    `CHK(q, 8'h00)
    wr_reg(uaaf_pkg::ADDR_TX_DATA, 8'ha5);
    fr = {1'b1, 8'ha5, 1'b0};
    repeat (8) @(posedge clk);
    // Mid-bit samples of the outgoing frame
    for (int i = 0; i < 10; i++) begin
      #1 `CHK(tx, fr[i])
      repeat (16) @(posedge clk);
    end
    wr_reg(uaaf_pkg::ADDR_BAUD_CTRL, 8'h18);
    #1 `CHK(tx, 1'b0)
    wr_reg(uaaf_pkg::ADDR_BAUD_CTRL, 8'h88);
    rd_reg(uaaf_pkg::ADDR_BAUD_CTRL, q);
    `CHK(q[7], 1'b1)
    wr_reg(uaaf_pkg::ADDR_BAUD_CTRL, 8'h08);
    rd_reg(uaaf_pkg::ADDR_BAUD_CTRL, q);
    `CHK(q[7], 1'b0)
    // Calibration in mode 11, 128 clocks per bit
    wr_reg(uaaf_pkg::ADDR_BAUD_CTRL, 8'h09);
    rd_reg(uaaf_pkg::ADDR_DIV_LOW, q);
    `CHK(q, 8'h00)
    rem_u.send(8'h55, 128);
    #1 `CHK(rx_done, 1'b1)
    rd_reg(uaaf_pkg::ADDR_DIV_LOW, q);
    `CHK(q inside {8'h1f, 8'h20}, 1'b1)
    rd_reg(uaaf_pkg::ADDR_DIV_HIGH, q);
    `CHK(q, 8'h00)
    rd_reg(uaaf_pkg::ADDR_BAUD_CTRL, q);
    `CHK(q[0], 1'b0)
    rd_reg(uaaf_pkg::ADDR_RX_CTRL, q);
    `CHK(q[2:1], 2'b00)
    rd_reg(uaaf_pkg::ADDR_STATUS, q);
    `CHK(q[1:0], 2'b11)
    rd_reg(uaaf_pkg::ADDR_RX_DATA, q);
    #1 `CHK(rx_done, 1'b0)
    conclude();
  end
endmodule
`default_nettype wire
